// file: pkg/atms_pkg.sv
// Constants and types of the converter trigger and mode sequencer.
// Assumes a 32-bit AHB-Lite register port and one 25 MHz clock.
// Operation
// R01: Software mode: enabling starts selected channel.
// R02: Completion stores result and raises interrupt.
// R03: Continuous modes restart while enable stays.
// R04: Busy flag set when conversion begins.
// R05: Busy flag low while awaiting hardware trigger.
// R06: Software mode: config write restarts conversion.
// R07: Edge field picks rising, falling or both.
// R08: Hardware mode: enable waits for valid trigger.
// R09: Hardware mode: after result, wait again.
// R10: Hardware mode: trigger during conversion restarts.
// R11: External mode: config write waits, no abort.
// R12: Timer field picks one of three timers.
// R13: Timer mode: config write stops, waits again.
// R14: Operation field selects four sequencing modes.
// R15: Channels 0 to 23, one result each.
// R16: Continuous select repeats channel, interrupt each.
// R17: Continuous scan: 0 to selected, then repeat.
// R18: One-shot select converts once, then stops.
// R19: One-shot scan converts range once, stops.
// R20: Diagnostic adds reference and ground conversions.
// R21: Discharge adds four cycles per conversion.
// R22: Compare enabled gates interrupt on condition.
// R23: Results sit in upper ten bits.
// R24: Interrupt is one-cycle pulse with result.
// R25: Clearing enable returns idle, aborts conversion.
package atms_pkg;
    localparam logic [7:0] OFS_MODE0 = 8'h00;
    localparam logic [7:0] OFS_MODE2 = 8'h04;
    localparam logic [7:0] OFS_CHSEL = 8'h08;
    localparam logic [7:0] OFS_CMPMODE = 8'h0C;
    localparam logic [7:0] OFS_CMPTHR = 8'h10;
    localparam logic [7:0] OFS_RES_BASE = 8'h40;
    localparam logic [7:0] OFS_DIAG_HIGH = 8'hA0;
    localparam logic [7:0] OFS_DIAG_GND = 8'hA4;
    localparam int M0_ENABLE = 7;
    localparam int M0_BUSY = 6;
    localparam int M0_OPMODE = 4;
    localparam int M0_EDGE = 2;
    localparam int M0_HWTRIG = 0;
    localparam int M2_DISC = 0;
    localparam int M2_DIAG = 1;
    localparam int M2_TMR = 2;
    localparam int CMP_EN = 7;
    localparam int CMP_POL = 6;
    localparam int RES_SHIFT = 6;
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [9:0] RST_RES = 10'h000;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] TMR_EXT = 2'h0;
    localparam logic [4:0] LAST_CH = 5'h17;
    localparam logic [4:0] SLOT_DIAG_HIGH = 5'h18;
    localparam logic [4:0] SLOT_DIAG_GND = 5'h19;
    localparam logic [3:0] DISC_CYC = 4'h4;
    localparam logic [3:0] SAMPLE_CYC = 4'h8;
    localparam logic [3:0] BIT_CYC = 4'h4;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_CONV = 3'b100
    } atms_state_e;
    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_DISC = 4'b0010,
        PH_SAMP = 4'b0100,
        PH_BITS = 4'b1000
    } atms_phase_e;
endpackage : atms_pkg

// file: verilog/atms_sar.sv
// Successive-approximation stepper: discharge, sample, ten bit trials.
// Assumes an analog comparator outside, answering on cmp_in asynchronously.
`timescale 1ns/10ps
module atms_sar (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire logic abort,
    input wire logic discharge_en,
    input wire logic cmp_in,
    output logic done,
    output logic [9:0] result,
    output logic sample_hold,
    output logic discharging
);
    atms_pkg::atms_phase_e phase, next_phase;
    logic [3:0] cnt, next_cnt, bitn, next_bitn;
    logic [9:0] next_sar;
    logic next_done, cmp_meta, cmp_sync;

    always_comb begin
        next_phase = phase;
        next_cnt = cnt;
        next_bitn = bitn;
        next_sar = result;
        next_done = 1'b0;
        if (start) begin
            next_phase = discharge_en ? atms_pkg::PH_DISC : atms_pkg::PH_SAMP; // R21
            next_cnt = (discharge_en ? atms_pkg::DISC_CYC : atms_pkg::SAMPLE_CYC) - 4'h1;
            next_sar = 10'h000;
        end else if (abort) begin
            next_phase = atms_pkg::PH_IDLE;
        end else begin
            unique case (phase)
                atms_pkg::PH_IDLE: next_cnt = 4'h0;
                atms_pkg::PH_DISC, atms_pkg::PH_SAMP: begin
                    next_cnt = cnt - 4'h1;
                    if (cnt == 4'h0 && phase == atms_pkg::PH_DISC) begin
                        next_phase = atms_pkg::PH_SAMP;
                        next_cnt = atms_pkg::SAMPLE_CYC - 4'h1;
                    end else if (cnt == 4'h0) begin
                        next_phase = atms_pkg::PH_BITS;
                        next_cnt = atms_pkg::BIT_CYC - 4'h1;
                        next_bitn = 4'h9;
                        next_sar = 10'h200;
                    end
                end
                atms_pkg::PH_BITS: begin
                    next_cnt = cnt - 4'h1;
                    if (cnt == 4'h0) begin
                        next_sar[bitn] = cmp_sync;
                        next_cnt = atms_pkg::BIT_CYC - 4'h1;
                        if (bitn == 4'h0) begin
                            next_done = 1'b1;
                            next_phase = atms_pkg::PH_IDLE;
                        end else begin
                            next_sar[bitn - 4'h1] = 1'b1;
                            next_bitn = bitn - 4'h1;
                        end
                    end
                end
                default: next_phase = atms_pkg::PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase <= atms_pkg::PH_IDLE;
            cnt <= 4'h0;
            bitn <= 4'h0;
            result <= 10'h000;
            done <= 1'b0;
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            phase <= next_phase;
            cnt <= next_cnt;
            bitn <= next_bitn;
            result <= next_sar;
            done <= next_done;
            cmp_meta <= cmp_in;
            cmp_sync <= cmp_meta;
        end
    end

    assign sample_hold = (phase == atms_pkg::PH_SAMP);
    assign discharging = (phase == atms_pkg::PH_DISC);
endmodule : atms_sar

// file: verilog/atms_top.sv
// Converter sequencer: trigger selection, channel sequencing, results, AHB-Lite registers.
// Assumes the analog mux, ladder and comparator outside; timer events on clk.
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module atms_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic ext_trigger_pin,
    input wire logic timer_event_a,
    input wire logic timer_event_b,
    input wire logic timer_event_c,
    input wire logic cmp_in,
    output logic [4:0] ana_sel,
    output logic sample_hold,
    output logic discharging,
    output logic [9:0] sar_trial,
    output logic conv_busy_flag,
    output logic conv_end_irq
);
    function automatic logic is_cfg(input logic [7:0] a);
        is_cfg = (a == atms_pkg::OFS_MODE0) || (a == atms_pkg::OFS_MODE2) ||
                 (a == atms_pkg::OFS_CHSEL) || (a == atms_pkg::OFS_CMPMODE) ||
                 (a == atms_pkg::OFS_CMPTHR);
    endfunction : is_cfg

    // Bus and register state
    logic dp_write, next_dp_write, rd_pend, next_rd_pend;
    logic [7:0] dp_addr, next_dp_addr;
    logic [31:0] next_hrdata, rd_val;
    logic conv_enable, next_conv_enable, hw_trig, next_hw_trig;
    logic [1:0] op_mode, next_op_mode, edge_sel, next_edge_sel;
    logic [1:0] timer_trig_sel, next_timer_trig_sel;
    logic discharge_enable, next_discharge_enable, diag_enable, next_diag_enable;
    logic [4:0] channel_select_reg, next_channel_select_reg;
    logic compare_enable, next_compare_enable, compare_polarity, next_compare_polarity;
    logic [7:0] compare_threshold_reg, next_compare_threshold_reg;
    logic [9:0] result_reg [0:23];
    logic [9:0] diag_high_result, diag_ground_result;
    logic cfg_wr, m0_wr;
    logic ap_valid;

    assign ap_valid = hsel && htrans[1] && hready;
    // Reads take one wait state so a read right behind a write sees the new value
    assign hreadyout = !rd_pend;
    assign hresp = 1'b0;

    always_comb begin
        next_dp_write = ap_valid && hwrite;
        next_rd_pend = ap_valid && !hwrite;
        next_dp_addr = ap_valid ? haddr[7:0] : dp_addr;
        rd_val = 32'h0000_0000;
        if (dp_addr >= atms_pkg::OFS_RES_BASE && dp_addr < atms_pkg::OFS_DIAG_HIGH &&
            dp_addr[1:0] == 2'h0) begin
            rd_val[15:0] = {result_reg[5'(dp_addr[7:2] - 6'h10)], 6'h00}; // R23
        end else begin
            case (dp_addr)
                atms_pkg::OFS_MODE0: rd_val[7:0] = {conv_enable, conv_busy_flag, op_mode,
                                                    edge_sel, 1'b0, hw_trig};
                atms_pkg::OFS_MODE2: rd_val[3:0] = {timer_trig_sel, diag_enable,
                                                    discharge_enable};
                atms_pkg::OFS_CHSEL: rd_val[4:0] = channel_select_reg;
                atms_pkg::OFS_CMPMODE: rd_val[7:6] = {compare_enable, compare_polarity};
                atms_pkg::OFS_CMPTHR: rd_val[7:0] = compare_threshold_reg;
                atms_pkg::OFS_DIAG_HIGH: rd_val[15:0] = {diag_high_result, 6'h00}; // R20
                atms_pkg::OFS_DIAG_GND: rd_val[15:0] = {diag_ground_result, 6'h00};
                default: rd_val = 32'h0000_0000;
            endcase
        end
        next_hrdata = rd_pend ? rd_val : hrdata;
    end

    always_comb begin
        next_conv_enable = conv_enable;
        next_op_mode = op_mode;
        next_edge_sel = edge_sel;
        next_hw_trig = hw_trig;
        next_discharge_enable = discharge_enable;
        next_diag_enable = diag_enable;
        next_timer_trig_sel = timer_trig_sel;
        next_channel_select_reg = channel_select_reg;
        next_compare_enable = compare_enable;
        next_compare_polarity = compare_polarity;
        next_compare_threshold_reg = compare_threshold_reg;
        m0_wr = dp_write && (dp_addr == atms_pkg::OFS_MODE0);
        cfg_wr = dp_write && is_cfg(dp_addr);
        if (dp_write) begin
            case (dp_addr)
                atms_pkg::OFS_MODE0: begin
                    next_conv_enable = hwdata[atms_pkg::M0_ENABLE];
                    next_op_mode = hwdata[atms_pkg::M0_OPMODE +: 2]; // R14
                    next_edge_sel = hwdata[atms_pkg::M0_EDGE +: 2];
                    next_hw_trig = hwdata[atms_pkg::M0_HWTRIG];
                end
                atms_pkg::OFS_MODE2: begin
                    next_discharge_enable = hwdata[atms_pkg::M2_DISC];
                    next_diag_enable = hwdata[atms_pkg::M2_DIAG];
                    next_timer_trig_sel = hwdata[atms_pkg::M2_TMR +: 2];
                end
                atms_pkg::OFS_CHSEL: next_channel_select_reg = (hwdata[4:0] > atms_pkg::LAST_CH) ?
                    atms_pkg::LAST_CH : hwdata[4:0]; // R15
                atms_pkg::OFS_CMPMODE: begin
                    next_compare_enable = hwdata[atms_pkg::CMP_EN];
                    next_compare_polarity = hwdata[atms_pkg::CMP_POL];
                end
                atms_pkg::OFS_CMPTHR: next_compare_threshold_reg = hwdata[7:0];
                default: next_hw_trig = hw_trig;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dp_write <= 1'b0;
            rd_pend <= 1'b0;
            dp_addr <= atms_pkg::RST_REG8;
            hrdata <= 32'h0000_0000;
            conv_enable <= 1'b0;
            op_mode <= 2'h0;
            edge_sel <= 2'h0;
            hw_trig <= 1'b0;
            discharge_enable <= 1'b0;
            diag_enable <= 1'b0;
            timer_trig_sel <= 2'h0;
            channel_select_reg <= 5'h00;
            compare_enable <= 1'b0;
            compare_polarity <= 1'b0;
            compare_threshold_reg <= atms_pkg::RST_REG8;
        end else begin
            dp_write <= next_dp_write;
            rd_pend <= next_rd_pend;
            dp_addr <= next_dp_addr;
            hrdata <= next_hrdata;
            conv_enable <= next_conv_enable;
            op_mode <= next_op_mode;
            edge_sel <= next_edge_sel;
            hw_trig <= next_hw_trig;
            discharge_enable <= next_discharge_enable;
            diag_enable <= next_diag_enable;
            timer_trig_sel <= next_timer_trig_sel;
            channel_select_reg <= next_channel_select_reg;
            compare_enable <= next_compare_enable;
            compare_polarity <= next_compare_polarity;
            compare_threshold_reg <= next_compare_threshold_reg;
        end
    end

    // Trigger detection; the pin is asynchronous, timer events share clk
    logic ext_meta, ext_sync, ext_prev, ext_edge, trig, tmr_mode;
    logic [2:0] tmr_now, tmr_prev, tmr_rise;

    assign tmr_now = {timer_event_c, timer_event_b, timer_event_a};
    assign tmr_rise = tmr_now & ~tmr_prev;
    assign tmr_mode = (timer_trig_sel != atms_pkg::TMR_EXT);
    always_comb begin
        unique case (edge_sel) // R07
            atms_pkg::EDGE_FALL: ext_edge = !ext_sync && ext_prev;
            atms_pkg::EDGE_RISE: ext_edge = ext_sync && !ext_prev;
            default: ext_edge = ext_sync != ext_prev;
        endcase
        trig = hw_trig && (tmr_mode ? tmr_rise[2'(timer_trig_sel - 2'h1)] : ext_edge); // R12
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
            tmr_prev <= 3'h0;
        end else begin
            ext_meta <= ext_trigger_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            tmr_prev <= tmr_now;
        end
    end

    // Sequencer
    atms_pkg::atms_state_e state, next_state;
    logic [4:0] slot, next_slot, first_slot, cmp_ch;
    logic rewait, next_rewait, next_irq, sar_start, sar_abort, sar_done;
    logic scan, last_ch, seq_end, go_first, cmp_ok;
    logic [7:0] cmp_val;
    logic [9:0] sar_result;

    atms_sar u_sar (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(sar_start),
        .abort(sar_abort),
        .discharge_en(discharge_enable),
        .cmp_in(cmp_in),
        .done(sar_done),
        .result(sar_result),
        .sample_hold(sample_hold),
        .discharging(discharging)
    );
    assign sar_trial = sar_result;
    assign ana_sel = slot;
    assign conv_busy_flag = (state == atms_pkg::ST_CONV); // R04 R05

    always_comb begin
        scan = op_mode[0];
        last_ch = !scan || (slot == channel_select_reg);
        seq_end = (slot == atms_pkg::SLOT_DIAG_GND) ||
                  (slot < atms_pkg::SLOT_DIAG_HIGH && last_ch && !diag_enable);
        first_slot = next_op_mode[0] ? 5'h00 : next_channel_select_reg;
        // Scan compares channel 0 only, select compares the converted channel
        cmp_ch = scan ? 5'h00 : channel_select_reg;
        cmp_val = (slot == cmp_ch) ? sar_result[9:2] : result_reg[cmp_ch][9:2];
        cmp_ok = !compare_enable || (compare_polarity ? (cmp_val < compare_threshold_reg) :
                                     (cmp_val >= compare_threshold_reg)); // R22
        next_state = state;
        next_slot = slot;
        next_rewait = 1'b0;
        next_irq = 1'b0;
        sar_abort = 1'b0;
        go_first = 1'b0;
        if (cfg_wr && !next_conv_enable) begin
            next_state = atms_pkg::ST_IDLE; // R25
            sar_abort = 1'b1;
        end else begin
            unique case (state)
                atms_pkg::ST_IDLE: begin
                    if (m0_wr && next_conv_enable && next_hw_trig) begin
                        next_state = atms_pkg::ST_WAIT; // R08
                    end else if (m0_wr && next_conv_enable) begin
                        go_first = 1'b1; // R01
                    end
                end
                atms_pkg::ST_WAIT: go_first = trig || (m0_wr && !next_hw_trig); // R08
                atms_pkg::ST_CONV: begin
                    if (trig) begin
                        go_first = 1'b1; // R10
                    end else if (cfg_wr && !hw_trig) begin
                        go_first = 1'b1; // R06
                    end else if (cfg_wr && tmr_mode) begin
                        next_state = atms_pkg::ST_WAIT; // R13
                        sar_abort = 1'b1;
                    end else if (sar_done && (cfg_wr || rewait)) begin
                        next_state = atms_pkg::ST_WAIT; // R11
                    end else if (sar_done && !seq_end) begin
                        next_slot = (slot == atms_pkg::SLOT_DIAG_HIGH) ? atms_pkg::SLOT_DIAG_GND :
                                    (!last_ch) ? slot + 5'h01 : atms_pkg::SLOT_DIAG_HIGH; // R17 R20
                    end else if (sar_done) begin
                        next_irq = cmp_ok; // R02 R22
                        if (hw_trig) begin
                            next_state = atms_pkg::ST_WAIT; // R09
                        end else if (!op_mode[1]) begin
                            go_first = 1'b1; // R03 R16 R17
                        end else begin
                            next_state = atms_pkg::ST_IDLE; // R18 R19
                        end
                    end else begin
                        next_rewait = rewait || cfg_wr;
                    end
                end
                default: next_state = atms_pkg::ST_IDLE;
            endcase
        end
        if (go_first) begin
            next_state = atms_pkg::ST_CONV;
            next_slot = first_slot;
        end
        sar_start = go_first || (next_slot != slot);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= atms_pkg::ST_IDLE;
            slot <= 5'h00;
            rewait <= 1'b0;
            conv_end_irq <= 1'b0;
        end else begin
            state <= next_state;
            slot <= next_slot;
            rewait <= next_rewait;
            conv_end_irq <= next_irq; // R24
        end
    end

    // Results land in the same edge as the interrupt pulse
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i <= 23; i++) begin
                result_reg[i] <= atms_pkg::RST_RES;
            end
            diag_high_result <= atms_pkg::RST_RES;
            diag_ground_result <= atms_pkg::RST_RES;
        end else if (sar_done && state == atms_pkg::ST_CONV) begin
            if (slot == atms_pkg::SLOT_DIAG_HIGH) begin
                diag_high_result <= sar_result; // R20
            end else if (slot == atms_pkg::SLOT_DIAG_GND) begin
                diag_ground_result <= sar_result;
            end else begin
                result_reg[slot] <= sar_result; // R02 R15
            end
        end
    end

    // Checks
    logic sw_start_wr;
    assign sw_start_wr = m0_wr && next_conv_enable && !next_hw_trig;

    start_busy_a: assert property (@(posedge clk) disable iff (sys_rst) // R04
        sar_start |=> conv_busy_flag) else $error("busy flag not set at start");
    // The stepper must be out of discharge and sample too, or a wait could still be converting behind the flag
    wait_idle_a: assert property (@(posedge clk) disable iff (sys_rst) // R05
        state == atms_pkg::ST_WAIT |-> !conv_busy_flag && !sample_hold && !discharging)
        else $error("busy while waiting");
    irq_pulse_a: assert property (@(posedge clk) disable iff (sys_rst) // R24
        conv_end_irq |=> !conv_end_irq) else $error("interrupt longer than one cycle");
    irq_cause_a: assert property (@(posedge clk) disable iff (sys_rst) // R02
        conv_end_irq |-> $past(sar_done)) else $error("interrupt without completion");
    sw_start_a: assert property (@(posedge clk) disable iff (sys_rst) // R01
        sw_start_wr && state != atms_pkg::ST_CONV |-> sar_start ##1 conv_busy_flag)
        else $error("software enable did not start");
    dis_idle_a: assert property (@(posedge clk) disable iff (sys_rst) // R25
        m0_wr && !next_conv_enable |=> state == atms_pkg::ST_IDLE && !discharging)
        else $error("disable did not idle");
    trig_restart_a: assert property (@(posedge clk) disable iff (sys_rst) // R10
        state == atms_pkg::ST_CONV && trig && !(cfg_wr && !next_conv_enable)
        |-> sar_start ##1 slot == $past(first_slot)) else $error("trigger did not restart");
    // A restart inside the discharge legally stretches it, so only clean runs are judged
    disc_len_a: assert property (@(posedge clk) disable iff (sys_rst) // R21
        sar_start && discharge_enable ##1 (!sar_start && !sar_abort) [*4]
        |=> sample_hold && $past(discharging) && $past(discharging, 4))
        else $error("discharge length wrong");
    tmr_stop_a: assert property (@(posedge clk) disable iff (sys_rst) // R13
        state == atms_pkg::ST_CONV && cfg_wr && next_conv_enable && hw_trig && tmr_mode
        && !trig |=> state == atms_pkg::ST_WAIT) else $error("timer mode write did not stop");
    one_shot_a: assert property (@(posedge clk) disable iff (sys_rst) // R18
        conv_end_irq && op_mode[1] && !hw_trig && !$past(cfg_wr) |-> state == atms_pkg::ST_IDLE)
        else $error("one-shot did not stop");

    scan_irq_c: cover property (@(posedge clk) disable iff (sys_rst)
        conv_end_irq && scan && channel_select_reg > 5'h01);
    diag_c: cover property (@(posedge clk) disable iff (sys_rst)
        sar_done && slot == atms_pkg::SLOT_DIAG_GND);
    ext_restart_c: cover property (@(posedge clk) disable iff (sys_rst)
        state == atms_pkg::ST_CONV && trig && !tmr_mode);
endmodule : atms_top

// file: dv/atms_analog_model.sv
// Analog side model: every slot holds a fixed level, comparator answers the trial.
// Assumes ana_sel and sar_trial are registered on clk.
`timescale 1ns/10ps
module atms_analog_model (
    input wire logic [4:0] ana_sel,
    input wire logic [9:0] sar_trial,
    output logic cmp_in
);
    // Level differs per slot so a wrong channel shows in the result
    assign cmp_in = ({ana_sel, 5'h15} >= sar_trial);
endmodule : atms_analog_model

// file: dv/adc_trigger_mode_sequencer_bench.sv
// Bench of the converter sequencer: AHB-Lite master, trigger stimulus, irq scoreboard.
// Assumes the analog model answers at once.
`timescale 1ns/10ps
module adc_trigger_mode_sequencer_bench;
    logic clk = 1'b0, sys_rst = 1'b1, hwrite = 1'b0, pin = 1'b0;
    logic ta = 1'b0, tb = 1'b0, tc = 1'b0, rdy, hresp, cmp, sh, dis, busy, irq;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rdv, seed = 32'h8FD3;
    logic [1:0] htrans = 2'h0;
    logic [4:0] sel, ch;
    logic [9:0] trial;
    logic [4:0] q[$];
    int fail_count = 0, total_checks = 0;
    int dis_n = 0, sh_n = 0;
    always #20 clk = ~clk;
    atms_top i_dut (.clk(clk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
        .hreadyout(rdy), .hrdata(hrdata), .hresp(hresp), .ext_trigger_pin(pin),
        .timer_event_a(ta), .timer_event_b(tb), .timer_event_c(tc), .cmp_in(cmp),
        .ana_sel(sel), .sample_hold(sh), .discharging(dis), .sar_trial(trial),
        .conv_busy_flag(busy), .conv_end_irq(irq));
    atms_analog_model i_ana (.ana_sel(sel), .sar_trial(trial), .cmp_in(cmp));
    function automatic logic [31:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : nxt
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        rdv = hrdata;
        chk("hresp", 0, hresp);
    endtask : xf
    task automatic wt();
        for (int i = 0; i < 3000 && q.size() > 0; i++) @(posedge clk);
        chk("pending irqs", 0, q.size());
        $display("test step done");
    endtask : wt
    task automatic res(input logic [7:0] a, input logic [4:0] s);
        xf(1'b0, a, 0);
        chk("result", {16'h0, s, 5'h15, 6'h00}, rdv);
    endtask : res
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // Each interrupt pulse must show ana_sel equal to the oldest expected slot in the queue
    always @(posedge clk) begin
        if (dis === 1'b1) dis_n++;
        if (sh === 1'b1) sh_n++;
        if (irq === 1'b1) begin
            if (q.size() == 0) chk("spurious irq", 0, 1);
            else chk("irq slot", q.pop_front(), sel);
        end
    end
    initial begin
        #(40 * 20000);
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        ch = 5'(nxt() % 24);
        xf(1'b1, atms_pkg::OFS_CHSEL, ch);
        q.push_back(ch);
        xf(1'b1, atms_pkg::OFS_MODE0, 32'hA0);
        wt();
        repeat (80) @(posedge clk);
        chk("busy", 0, busy);
        chk("sample cycles", atms_pkg::SAMPLE_CYC, sh_n);
        chk("discharge cycles", 0, dis_n);
        res(atms_pkg::OFS_RES_BASE + {ch, 2'b00}, ch);
        xf(1'b0, 8'h30, 0);
        chk("unmapped", 0, rdv);
        xf(1'b1, atms_pkg::OFS_MODE0, 0);
        xf(1'b1, atms_pkg::OFS_MODE2, 32'h3);
        xf(1'b1, atms_pkg::OFS_CHSEL, 3);
        q.push_back(atms_pkg::SLOT_DIAG_GND);
        xf(1'b1, atms_pkg::OFS_MODE0, 32'hB0);
        wt();
        res(atms_pkg::OFS_DIAG_HIGH, atms_pkg::SLOT_DIAG_HIGH);
        res(atms_pkg::OFS_RES_BASE + 8'h08, 5'h02);
        // Six slots, each with its own discharge and sample phase
        chk("discharge cycles", 6 * atms_pkg::DISC_CYC, dis_n);
        chk("sample cycles", 7 * atms_pkg::SAMPLE_CYC, sh_n);
        xf(1'b1, atms_pkg::OFS_MODE2, 32'h8);
        xf(1'b1, atms_pkg::OFS_CHSEL, ch);
        xf(1'b1, atms_pkg::OFS_MODE0, 32'hA1);
        ta <= 1'b1;
        repeat (20) @(posedge clk);
        chk("busy waiting", 0, busy);
        q.push_back(ch);
        tb <= 1'b1;
        repeat (10) @(posedge clk);
        tb <= 1'b0;
        @(posedge clk);
        tb <= 1'b1;
        wt();
        xf(1'b1, atms_pkg::OFS_MODE2, 0);
        xf(1'b1, atms_pkg::OFS_MODE0, 32'hA5);
        repeat (20) @(posedge clk);
        q.push_back(ch);
        pin <= 1'b1;
        wt();
        xf(1'b1, atms_pkg::OFS_MODE0, 32'hA1);
        q.push_back(ch);
        pin <= 1'b0;
        wt();
        xf(1'b1, atms_pkg::OFS_MODE0, 32'h80);
        q.push_back(ch);
        q.push_back(ch);
        wt();
        xf(1'b1, atms_pkg::OFS_MODE0, 0);
        xf(1'b1, atms_pkg::OFS_CHSEL, 1);
        xf(1'b1, atms_pkg::OFS_CMPTHR, 32'hFF);
        xf(1'b1, atms_pkg::OFS_CMPMODE, 32'h80);
        xf(1'b1, atms_pkg::OFS_MODE0, 32'h90);
        repeat (200) @(posedge clk);
        chk("busy scan", 1, busy);
        // Continuous scan has already wrapped to channel 0 when the pulse comes
        q.push_back(5'h00);
        xf(1'b1, atms_pkg::OFS_CMPTHR, 32'h05);
        wt();
        xf(1'b1, atms_pkg::OFS_MODE0, 0);
        repeat (100) @(posedge clk);
        chk("busy idle", 0, busy);
        wrap_up();
    end
endmodule : adc_trigger_mode_sequencer_bench
